/* File: design/dacamp_pkg.sv */
// dacamp_pkg: constants for the converter/amplifier enable control block
// assumes byte-wide cpu register port with bit-write support
package dacamp_pkg;
  localparam logic [19:0] DACAMP_OFS_CLK_EN = 20'hF007A;
  localparam logic [19:0] DACAMP_OFS_PWR_SEL = 20'hF0440;
  localparam logic [19:0] DACAMP_OFS_MODE0 = 20'hF0480;
  localparam logic [19:0] DACAMP_OFS_MODE1 = 20'hF0481;
  localparam logic [19:0] DACAMP_OFS_DATA = 20'hF0482;
  localparam logic [19:0] DACAMP_OFS_S1_BASE = 20'hF0471;
  localparam logic [19:0] DACAMP_OFS_S2_BASE = 20'hF0472;
  localparam logic [19:0] DACAMP_OFS_CAL_BASE = 20'hF0490;
  localparam logic [19:0] DACAMP_OFS_PMC_A = 20'hF0061;
  localparam logic [19:0] DACAMP_OFS_PMC_B = 20'hF0064;
  localparam logic [19:0] DACAMP_UNIT_STRIDE = 20'h00004;
  localparam logic [7:0] DACAMP_RST_CLK_EN = 8'h00;
  localparam logic [7:0] DACAMP_RST_PWR_SEL = 8'h00;
  localparam logic [7:0] DACAMP_RST_MODE = 8'h00;
  localparam logic [11:0] DACAMP_RST_DATA = 12'h000;
  localparam logic [7:0] DACAMP_RST_S1 = 8'h00;
  localparam logic [7:0] DACAMP_RST_S2 = 8'h20;
  localparam logic [7:0] DACAMP_RST_CAL = 8'h00;
  localparam logic [7:0] DACAMP_RST_PMC = 8'hFF;
  localparam logic [7:0] DACAMP_CLK_EN_MASK = 8'hEF;
  localparam logic [7:0] DACAMP_PWR_SEL_MASK = 8'hF5;
  localparam logic [7:0] DACAMP_MODE0_MASK = 8'h81;
  localparam logic [7:0] DACAMP_MODE1_MASK = 8'h01;
  localparam int DACAMP_BIT_CONV_CLK = 7;
  localparam int DACAMP_BIT_CONV_PWR = 7;
  localparam int DACAMP_BIT_AMP_PWR0 = 4;
  localparam int DACAMP_BIT_TRIG_MODE = 7;
  localparam int DACAMP_BIT_RES = 0;
  localparam int DACAMP_BIT_FEEDBACK = 7;
  localparam int DACAMP_UNITS = 3;
  localparam int DACAMP_PORTS = 6;
endpackage : dacamp_pkg

/* File: design/dacamp_reg8.sv */
// dacamp_reg8: one byte register with sync clear and byte or bit write
// assumes at most one of byte or bit write per cycle
`timescale 1ns/100ps
module dacamp_reg8 #(
  parameter logic [7:0] RST_VAL = 8'h00,
  parameter logic [7:0] MASK = 8'hFF
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  input wire logic clr,
  // writes
  input wire logic wr_byte,
  input wire logic wr_bit,
  input wire logic [2:0] bit_sel,
  input wire logic bit_val,
  input wire logic [7:0] wdata,
  // contents
  output logic [7:0] q
);
  logic [7:0] q_nxt;
  logic [7:0] bit_mask;
  // single-bit write touches only the selected bit
  assign bit_mask = 8'h01 << bit_sel;
  assign q_nxt = clr ? RST_VAL : wr_byte ? (wdata & MASK) :
                 wr_bit ? (((q & ~bit_mask) | ({8{bit_val}} & bit_mask)) & MASK) : q;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      q <= RST_VAL;
    end else begin
      q <= q_nxt;
    end
  end
endmodule : dacamp_reg8

/* File: design/dacamp_ctrl.sv */
// dacamp_ctrl: clock/power gating of the converter and amplifier interlocks
// assumes a cpu byte port, one access per cycle, rdata valid one cycle after rd
// Summary of operation
// (RULE1) converter clock bit 0 stops its clock, resets it, blocks its register writes
// (RULE2) with clock bit 0, converter writes dropped and reads give reset values
// (RULE3) converter clock bit 1 supplies clock, registers read and write
// (RULE4) software sets clock bit 7 first and writes 0 to bit 4
// (RULE5) software writes 0 to power-select bits 1 and 3
// (RULE6) power-select bit 7 powers the converter; 0 after reset
// (RULE7) software powers converter before routing it to an amplifier
// (RULE8) amplifier outputs to a port are exclusive; unit 0 beats 1 beats 2
// (RULE9) software never sets feedback plus negative switches; follower uses 80H
// (RULE10) amplifier power forced off when all its input switches are open
// (RULE11) reset clears trim correction to 00H; software recopies factory code
// (RULE12) four analog ports become digital pins under two port mode registers
// (RULE13) software changes port mode only with amplifier off, not in analog use
// (RULE14) converter output updates on an event input as well as software
// (RULE15) trigger mode bit 0 software trigger, 1 hardware event trigger
// (RULE16) in software mode each data register write starts a conversion
// (RULE17) in hardware mode data writes do not start; event does
// (RULE18) resolution bit 0 uses 12-bit data, 1 uses 8-bit data
// (RULE19) single-bit writes change only the addressed bit
`timescale 1ns/100ps
module dacamp_ctrl
  import dacamp_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // cpu register port
  input wire logic [19:0] addr,
  input wire logic wr_byte,
  input wire logic wr_bit,
  input wire logic wr_word,
  input wire logic [2:0] bit_sel,
  input wire logic bit_val,
  input wire logic [15:0] wdata,
  input wire logic rd,
  output logic [15:0] rdata,
  // event link
  input wire logic event_link,
  // converter side
  output logic conv_clock_en,
  output logic conv_reset,
  output logic conv_power,
  output logic conv_start,
  output logic [11:0] conv_value,
  output logic conv_ref_internal,
  // amplifier side
  output logic [2:0] amplifier_power_on,
  output logic [17:0] amp_port_drive,
  output logic [7:0] port_digital_a,
  output logic [7:0] port_digital_b,
  output logic [23:0] trim_correction
);
  logic [7:0] clk_en_q, pwr_q, mode0_q, mode1_q, pmca_q, pmcb_q;
  logic [7:0] s1_q [DACAMP_UNITS];
  logic [7:0] s2_q [DACAMP_UNITS];
  logic [7:0] cal_q [DACAMP_UNITS];
  logic [11:0] data_r, data_nxt;
  logic conv_en, conv_clr, hw_mode, narrow;
  logic hit_ce, hit_pw, hit_m0, hit_m1, hit_dat, hit_pa, hit_pb;
  logic data_wr, sw_start, hw_start;
  logic [2:0] inputs_any;
  logic [17:0] drive_nxt;
  logic [15:0] rdata_nxt;
  logic port_clash;

  // address decode
  assign hit_ce = (addr == DACAMP_OFS_CLK_EN);
  assign hit_pw = (addr == DACAMP_OFS_PWR_SEL);
  assign hit_m0 = (addr == DACAMP_OFS_MODE0);
  assign hit_m1 = (addr == DACAMP_OFS_MODE1);
  assign hit_dat = (addr == DACAMP_OFS_DATA);
  assign hit_pa = (addr == DACAMP_OFS_PMC_A);
  assign hit_pb = (addr == DACAMP_OFS_PMC_B);

  // converter gating flags
  assign conv_en = clk_en_q[DACAMP_BIT_CONV_CLK]; // see (RULE3)
  assign conv_clr = ~conv_en; // converter held in reset, see (RULE1)
  assign hw_mode = mode0_q[DACAMP_BIT_TRIG_MODE]; // see (RULE15)
  assign narrow = mode0_q[DACAMP_BIT_RES]; // see (RULE18)

  // always-on registers with bit access
  dacamp_reg8 #(.RST_VAL(DACAMP_RST_CLK_EN), .MASK(DACAMP_CLK_EN_MASK)) u_clk_en (
    .clock(clock), .rst(rst), .clr(1'b0),
    .wr_byte(wr_byte & hit_ce), .wr_bit(wr_bit & hit_ce), // see (RULE19)
    .bit_sel(bit_sel), .bit_val(bit_val), .wdata(wdata[7:0]), .q(clk_en_q)
  );
  dacamp_reg8 #(.RST_VAL(DACAMP_RST_PWR_SEL), .MASK(DACAMP_PWR_SEL_MASK)) u_pwr (
    .clock(clock), .rst(rst), .clr(1'b0),
    .wr_byte(wr_byte & hit_pw), .wr_bit(wr_bit & hit_pw), // see (RULE19)
    .bit_sel(bit_sel), .bit_val(bit_val), .wdata(wdata[7:0]), .q(pwr_q)
  );
  dacamp_reg8 #(.RST_VAL(DACAMP_RST_PMC)) u_pmca (
    .clock(clock), .rst(rst), .clr(1'b0),
    .wr_byte(wr_byte & hit_pa), .wr_bit(wr_bit & hit_pa), // see (RULE12)
    .bit_sel(bit_sel), .bit_val(bit_val), .wdata(wdata[7:0]), .q(pmca_q)
  );
  dacamp_reg8 #(.RST_VAL(DACAMP_RST_PMC)) u_pmcb (
    .clock(clock), .rst(rst), .clr(1'b0),
    .wr_byte(wr_byte & hit_pb), .wr_bit(wr_bit & hit_pb), // see (RULE12)
    .bit_sel(bit_sel), .bit_val(bit_val), .wdata(wdata[7:0]), .q(pmcb_q)
  );

  // converter mode registers, cleared and write-locked while unclocked
  dacamp_reg8 #(.RST_VAL(DACAMP_RST_MODE), .MASK(DACAMP_MODE0_MASK)) u_mode0 (
    .clock(clock), .rst(rst), .clr(conv_clr), // see (RULE1)
    .wr_byte(wr_byte & hit_m0 & conv_en), .wr_bit(1'b0), // see (RULE2)
    .bit_sel(bit_sel), .bit_val(bit_val), .wdata(wdata[7:0]), .q(mode0_q)
  );
  dacamp_reg8 #(.RST_VAL(DACAMP_RST_MODE), .MASK(DACAMP_MODE1_MASK)) u_mode1 (
    .clock(clock), .rst(rst), .clr(conv_clr), // see (RULE1)
    .wr_byte(wr_byte & hit_m1 & conv_en), .wr_bit(1'b0), // see (RULE2)
    .bit_sel(bit_sel), .bit_val(bit_val), .wdata(wdata[7:0]), .q(mode1_q)
  );

  // per-unit switch and trim registers
  for (genvar u = 0; u < DACAMP_UNITS; u++) begin : g_unit
    logic h_s1, h_s2, h_cal;
    assign h_s1 = (addr == 20'(DACAMP_OFS_S1_BASE + DACAMP_UNIT_STRIDE * u));
    assign h_s2 = (addr == 20'(DACAMP_OFS_S2_BASE + DACAMP_UNIT_STRIDE * u));
    assign h_cal = (addr == 20'(DACAMP_OFS_CAL_BASE + u));
    dacamp_reg8 #(.RST_VAL(DACAMP_RST_S1)) u_s1 (
      .clock(clock), .rst(rst), .clr(1'b0),
      .wr_byte(wr_byte & h_s1), .wr_bit(wr_bit & h_s1),
      .bit_sel(bit_sel), .bit_val(bit_val), .wdata(wdata[7:0]), .q(s1_q[u])
    );
    dacamp_reg8 #(.RST_VAL(DACAMP_RST_S2)) u_s2 (
      .clock(clock), .rst(rst), .clr(1'b0),
      .wr_byte(wr_byte & h_s2), .wr_bit(wr_bit & h_s2),
      .bit_sel(bit_sel), .bit_val(bit_val), .wdata(wdata[7:0]), .q(s2_q[u])
    );
    // trim cleared by system reset only, see (RULE11)
    dacamp_reg8 #(.RST_VAL(DACAMP_RST_CAL)) u_cal (
      .clock(clock), .rst(rst), .clr(1'b0),
      .wr_byte(wr_byte & h_cal), .wr_bit(1'b0),
      .bit_sel(bit_sel), .bit_val(bit_val), .wdata(wdata[7:0]), .q(cal_q[u])
    );
    // any closed input switch (negative or positive side, incl. converter while powered)
    assign inputs_any[u] = (|s1_q[u]) | (|s2_q[u][5:0]) |
                           (s2_q[u][7] & pwr_q[DACAMP_BIT_CONV_PWR]);
  end

  // data register: wide or narrow write, cleared while unclocked
  assign data_wr = conv_en & (wr_word | wr_byte) & hit_dat; // see (RULE2)
  assign data_nxt = conv_clr ? DACAMP_RST_DATA :
                    (data_wr & wr_word) ? wdata[11:0] :
                    data_wr ? {4'h0, wdata[7:0]} : data_r;
  assign sw_start = data_wr & ~hw_mode; // see (RULE16)
  assign hw_start = conv_en & hw_mode & event_link; // see (RULE14) (RULE17)

  // exclusive output routing: lowest unit wins each port
  always_comb begin
    drive_nxt = 18'h00000;
    for (int p = 0; p < DACAMP_PORTS; p++) begin
      if (s1_q[0][p] & amplifier_power_on[0]) begin
        drive_nxt[p] = 1'b1; // see (RULE8)
      end else if (s1_q[1][p] & amplifier_power_on[1]) begin
        drive_nxt[DACAMP_PORTS + p] = 1'b1;
      end else if (s1_q[2][p] & amplifier_power_on[2]) begin
        drive_nxt[2 * DACAMP_PORTS + p] = 1'b1;
      end
    end
  end

  // read mux; converter registers read as reset values when unclocked
  always_comb begin
    rdata_nxt = 16'h0000;
    if (hit_ce) rdata_nxt = {8'h00, clk_en_q};
    else if (hit_pw) rdata_nxt = {8'h00, pwr_q};
    else if (hit_pa) rdata_nxt = {8'h00, pmca_q};
    else if (hit_pb) rdata_nxt = {8'h00, pmcb_q};
    else if (hit_m0) rdata_nxt = {8'h00, mode0_q}; // see (RULE2)
    else if (hit_m1) rdata_nxt = {8'h00, mode1_q};
    else if (hit_dat) rdata_nxt = narrow ? {8'h00, data_r[7:0]} : {4'h0, data_r};
    for (int u = 0; u < DACAMP_UNITS; u++) begin
      if (addr == DACAMP_OFS_CAL_BASE + 20'(u)) rdata_nxt = {8'h00, cal_q[u]};
    end
  end

  // output flops
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      data_r <= DACAMP_RST_DATA;
      rdata <= 16'h0000;
      conv_clock_en <= 1'b0;
      conv_reset <= 1'b1;
      conv_power <= 1'b0;
      conv_start <= 1'b0;
      conv_value <= DACAMP_RST_DATA;
      conv_ref_internal <= 1'b0;
      amplifier_power_on <= 3'h0;
      amp_port_drive <= 18'h00000;
      port_digital_a <= DACAMP_RST_PMC;
      port_digital_b <= DACAMP_RST_PMC;
      trim_correction <= 24'h000000;
    end else begin
      data_r <= data_nxt;
      rdata <= rd ? rdata_nxt : rdata;
      conv_clock_en <= conv_en; // see (RULE1) (RULE3)
      conv_reset <= conv_clr; // see (RULE1)
      conv_power <= pwr_q[DACAMP_BIT_CONV_PWR]; // see (RULE6)
      conv_start <= sw_start | hw_start;
      if (sw_start | hw_start) begin
        conv_value <= (narrow ? {data_nxt[7:0], 4'h0} : data_nxt); // see (RULE18)
      end
      conv_ref_internal <= mode1_q[0];
      // forced off with all inputs open, see (RULE10)
      amplifier_power_on <= pwr_q[DACAMP_BIT_AMP_PWR0 +: 3] & inputs_any;
      amp_port_drive <= drive_nxt;
      port_digital_a <= pmca_q;
      port_digital_b <= pmcb_q;
      trim_correction <= {cal_q[2], cal_q[1], cal_q[0]};
    end
  end

  // checks; any port driven by two units at once is a clash
  assign port_clash = |((amp_port_drive[5:0] & amp_port_drive[11:6]) |
                        (amp_port_drive[5:0] & amp_port_drive[17:12]) |
                        (amp_port_drive[11:6] & amp_port_drive[17:12]));
  property p_unclocked_reset;
    @(posedge clock) disable iff (rst) !conv_en |=> conv_reset && !conv_clock_en;
  endproperty
  a_unclocked_reset: assert property (p_unclocked_reset) else $error("conv not reset"); // see (RULE1)
  property p_locked_write;
    @(posedge clock) disable iff (rst) (!conv_en && wr_byte && hit_m0) |=> mode0_q == 8'h00;
  endproperty
  a_locked_write: assert property (p_locked_write) else $error("locked write took"); // see (RULE2)
  property p_power;
    @(posedge clock) disable iff (rst) 1'b1 |=> conv_power == $past(pwr_q[7]);
  endproperty
  a_power: assert property (p_power) else $error("conv power wrong"); // see (RULE6)
  property p_excl;
    @(posedge clock) disable iff (rst) !port_clash;
  endproperty
  a_excl: assert property (p_excl) else $error("port shared"); // see (RULE8)
  property p_forced_off;
    @(posedge clock) disable iff (rst) !inputs_any[0] |=> !amplifier_power_on[0];
  endproperty
  a_forced_off: assert property (p_forced_off) else $error("amp left powered"); // see (RULE10)
  property p_sw_start;
    @(posedge clock) disable iff (rst) (conv_en && !hw_mode && wr_word && hit_dat) |=> conv_start;
  endproperty
  a_sw_start: assert property (p_sw_start) else $error("no sw start"); // see (RULE16)
  property p_hw_nostart;
    @(posedge clock) disable iff (rst) (hw_mode && !event_link) |=> !conv_start;
  endproperty
  a_hw_nostart: assert property (p_hw_nostart) else $error("hw mode started by write"); // see (RULE17)
  property p_bitwrite;
    @(posedge clock) disable iff (rst) (wr_bit && hit_ce && bit_sel == 3'h7)
      |=> clk_en_q[6:0] == $past(clk_en_q[6:0]);
  endproperty
  a_bitwrite: assert property (p_bitwrite) else $error("bit write leaked"); // see (RULE19)
endmodule : dacamp_ctrl

/* File: dv/tb_top.sv */
// tb_top: self-checking bench for the converter/amplifier enable control
// assumes dacamp_ctrl alone, driven at falling clock edges, one access at a time
`timescale 1ns/100ps
module tb_top;
  import dacamp_pkg::*;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic [19:0] addr = 20'h00000;
  logic wr_byte = 1'b0;
  logic wr_bit = 1'b0;
  logic wr_word = 1'b0;
  logic [2:0] bit_sel = 3'h0;
  logic bit_val = 1'b0;
  logic [15:0] wdata = 16'h0000;
  logic rd = 1'b0;
  logic event_link = 1'b0;
  logic [15:0] rdata;
  logic conv_clock_en, conv_reset, conv_power, conv_start, conv_ref_internal;
  logic [11:0] conv_value;
  logic [2:0] amplifier_power_on;
  logic [17:0] amp_port_drive;
  logic [7:0] port_digital_a, port_digital_b;
  logic [23:0] trim_correction;
  logic [31:0] seed = 32'h4391;
  int n_errors = 0;
  int n_checks = 0;

  dacamp_ctrl dacamp_ctrl_i (.clock(clock), .rst(rst), .addr(addr), .wr_byte(wr_byte),
    .wr_bit(wr_bit), .wr_word(wr_word), .bit_sel(bit_sel), .bit_val(bit_val),
    .wdata(wdata), .rd(rd), .rdata(rdata), .event_link(event_link),
    .conv_clock_en(conv_clock_en), .conv_reset(conv_reset), .conv_power(conv_power),
    .conv_start(conv_start), .conv_value(conv_value), .conv_ref_internal(conv_ref_internal),
    .amplifier_power_on(amplifier_power_on), .amp_port_drive(amp_port_drive),
    .port_digital_a(port_digital_a), .port_digital_b(port_digital_b),
    .trim_correction(trim_correction));

  // free-running 100 MHz clock
  always #5 clock = ~clock;

  // xorshift source, fixed start so runs repeat
  function automatic logic [31:0] xrand();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xrand

  // lowest unit wins each port, the others lose that switch
  function automatic logic [17:0] exp_drive(input logic [17:0] s);
    logic [17:0] r;
    r = 18'h00000;
    for (int p = 0; p < 6; p++) begin
      for (int u = 2; u >= 0; u--) begin
        if (s[u * 6 + p]) begin
          for (int k = 0; k < 3; k++) r[k * 6 + p] = (k == u);
        end
      end
    end
    return r;
  endfunction : exp_drive

  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic finish_test();
    $display("checks=%0d errors=%0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : finish_test

  // strobe held across one rising edge, dropped at the next falling edge
  task automatic wr(input logic [19:0] a, input logic [15:0] d, input logic word);
    @(negedge clock);
    addr = a;
    wdata = d;
    wr_byte = ~word;
    wr_word = word;
    @(negedge clock);
    wr_byte = 1'b0;
    wr_word = 1'b0;
  endtask : wr

  task automatic wb(input logic [19:0] a, input logic [2:0] b, input logic v);
    @(negedge clock);
    addr = a;
    bit_sel = b;
    bit_val = v;
    wr_bit = 1'b1;
    @(negedge clock);
    wr_bit = 1'b0;
  endtask : wb

  task automatic rd_chk(input logic [19:0] a, input logic [15:0] exp);
    @(negedge clock);
    addr = a;
    rd = 1'b1;
    @(negedge clock);
    rd = 1'b0;
    chk({8'h00, rdata}, {8'h00, exp});
  endtask : rd_chk

  // counts start pulses seen over the next few cycles
  task automatic starts(output logic [23:0] c);
    c = 24'h000000;
    repeat (4) begin
      if (conv_start === 1'b1) c = c + 24'h000001;
      @(negedge clock);
    end
  endtask : starts

  // hang guard, well beyond the expected run
  initial begin
    #200000;
    n_errors++;
    finish_test();
  end

  initial begin
    logic [7:0] pw, v;
    logic [11:0] d;
    logic [17:0] sv;
    logic [23:0] c;
    int b;
    repeat (6) @(posedge clock);
    @(negedge clock);
    rst = 1'b0;
    chk({conv_reset, conv_clock_en, conv_power}, 24'h000004);
    chk(trim_correction, 24'h000000);
    rd_chk(DACAMP_OFS_CLK_EN, 16'h0000);
    rd_chk(DACAMP_OFS_PWR_SEL, 16'h0000);
    rd_chk(20'hF0000, 16'h0000);
    // converter writes while its clock is gated are lost
    wr(DACAMP_OFS_MODE0, 16'h0081, 1'b0);
    wr(DACAMP_OFS_DATA, 16'h0ABC, 1'b1);
    starts(c);
    chk(c, 24'h000000);
    rd_chk(DACAMP_OFS_MODE0, 16'h0000);
    rd_chk(DACAMP_OFS_DATA, 16'h0000);
    // enable with random neighbours, bit 4 kept clear
    v = (xrand() & DACAMP_CLK_EN_MASK) | 8'h80;
    wr(DACAMP_OFS_CLK_EN, {8'h00, v}, 1'b0);
    rd_chk(DACAMP_OFS_CLK_EN, {8'h00, v});
    repeat (2) @(negedge clock);
    chk({conv_reset, conv_clock_en}, 24'h000001);
    // software trigger, four data words, each counted, checked and read back
    for (int i = 0; i < 4; i++) begin
      d = xrand();
      wr(DACAMP_OFS_DATA, {4'h0, d}, 1'b1);
      starts(c);
      chk(c, 24'h000001);
      chk(conv_value, d);
      rd_chk(DACAMP_OFS_DATA, {4'h0, d});
    end
    // narrow resolution, value left-aligned
    wr(DACAMP_OFS_MODE0, 16'h0001, 1'b0);
    v = xrand();
    wr(DACAMP_OFS_DATA, {8'h00, v}, 1'b0);
    starts(c);
    chk(c, 24'h000001);
    chk(conv_value, {v, 4'h0});
    // hardware trigger: data write is silent, the event starts it
    wr(DACAMP_OFS_MODE0, 16'h0080, 1'b0);
    d = xrand();
    wr(DACAMP_OFS_DATA, {4'h0, d}, 1'b1);
    starts(c);
    chk(c, 24'h000000);
    @(negedge clock);
    event_link = 1'b1;
    @(negedge clock);
    event_link = 1'b0;
    starts(c);
    chk(c, 24'h000001);
    chk(conv_value, d);
    // single-bit writes touch only their bit
    pw = 8'h00;
    for (int i = 0; i < 12; i++) begin
      b = xrand() % 8;
      v = xrand();
      if (DACAMP_PWR_SEL_MASK[b]) begin
        wb(DACAMP_OFS_PWR_SEL, b[2:0], v[0]);
        pw[b] = v[0];
        rd_chk(DACAMP_OFS_PWR_SEL, {8'h00, pw});
      end
    end
    // unit 0 loses all input switches, unit 1 keeps its reset positive switch
    wr(DACAMP_OFS_S2_BASE, 16'h0000, 1'b0);
    wb(DACAMP_OFS_PWR_SEL, 3'h7, 1'b1);
    wb(DACAMP_OFS_PWR_SEL, 3'h4, 1'b1);
    wb(DACAMP_OFS_PWR_SEL, 3'h5, 1'b1);
    wb(DACAMP_OFS_PWR_SEL, 3'h6, 1'b1);
    pw = pw | 8'hF0;
    repeat (2) @(negedge clock);
    chk(conv_power, 24'h000001);
    chk(amplifier_power_on, {pw[6], 2'b10});
    // output switches, all-ports corner first, then random overlaps
    for (int i = 0; i < 6; i++) begin
      sv = (i == 0) ? 18'h3FFFF : 18'({xrand(), 2'b00});
      for (int u = 0; u < 3; u++) begin
        wr(DACAMP_OFS_S1_BASE + DACAMP_UNIT_STRIDE * u, {10'h000, sv[u * 6 +: 6]}, 1'b0);
      end
      repeat (2) @(negedge clock);
      chk(amp_port_drive, exp_drive(sv));
    end
    // trim and port mode with amplifiers off
    wr(DACAMP_OFS_PWR_SEL, {8'h00, pw & 8'h8F}, 1'b0);
    v = xrand();
    wr(DACAMP_OFS_CAL_BASE + 20'h00001, {8'h00, v}, 1'b0);
    wr(DACAMP_OFS_PMC_A, {8'h00, ~v}, 1'b0);
    wr(DACAMP_OFS_PMC_B, {8'h00, v}, 1'b0);
    wr(DACAMP_OFS_MODE1, 16'h0001, 1'b0);
    repeat (2) @(negedge clock);
    chk(trim_correction[15:8], v);
    chk(port_digital_a, 8'(~v));
    chk(port_digital_b, v);
    chk(conv_ref_internal, 24'h000001);
    // gating the clock again resets the converter side
    wb(DACAMP_OFS_CLK_EN, 3'h7, 1'b0);
    repeat (2) @(negedge clock);
    chk(conv_reset, 24'h000001);
    chk(conv_ref_internal, 24'h000000);
    rd_chk(DACAMP_OFS_MODE0, 16'h0000);
    // second reset mid-run
    @(negedge clock);
    rst = 1'b1;
    @(negedge clock);
    rst = 1'b0;
    chk(trim_correction, 24'h000000);
    chk({port_digital_a, port_digital_b}, 24'h00FFFF);
    rd_chk(DACAMP_OFS_PWR_SEL, 16'h0000);
    finish_test();
  end
endmodule : tb_top
